// ===== pdw_pkg.sv
// Constants, command word layout and register map of the DAC register word decoder
package pdw_pkg;

	// ***********************************************************
	// Sizes
	// ***********************************************************
	localparam int CMD_W = 29;
	localparam int DATA_W = 16;
	localparam int GAIN_W = 15;
	localparam int CHAN_N = 4;
	localparam int LEVEL_W = 6;
	localparam int LEVEL_N = 64;
	localparam int ADDR_W = 8;
	localparam int BUS_W = 32;

	// ***********************************************************
	// Command word field positions
	// ***********************************************************
	localparam int RDWR_POS = 28;
	localparam int CHAN_HI_POS = 27;
	localparam int CHAN_LO_POS = 24;
	localparam int KIND_HI_POS = 23;
	localparam int KIND_LO_POS = 22;
	localparam int SET_HI_POS = 21;
	localparam int SET_LO_POS = 19;
	localparam int LVL_HI_POS = 18;
	localparam int LVL_LO_POS = 16;
	localparam int DATA_HI_POS = 15;
	localparam int GAIN_LO_POS = 1;

	// ***********************************************************
	// Register map
	// ***********************************************************
	localparam logic [ADDR_W-1:0] REG_CMD_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_RDBACK_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CTRL_OFS = 8'h0C;
	localparam int CTRL_EN_POS = 0;
	localparam int STAT_RBVALID_POS = 0;
	localparam int STAT_PEND_POS = 1;
	localparam int STAT_KIND_LO_POS = 2;

	// ***********************************************************
	// Reset values and fixed codes
	// ***********************************************************
	localparam logic [BUS_W-1:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 15'h7FFF;
	localparam logic [DATA_W-1:0] OFFS_RESET = 16'h8000;
	localparam logic [DATA_W-1:0] INPUT_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] OFFSET_DAC_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CODE_MID = 16'h8000;
	localparam logic [LEVEL_W-1:0] OFFSET_DAC_ADDR = 6'h00;

	// ***********************************************************
	// Types
	// ***********************************************************
	typedef enum logic [1:0] {
		KIND_SYS = 2'b00,
		KIND_GAIN = 2'b01,
		KIND_OFFS = 2'b10,
		KIND_INPUT = 2'b11
	} pdw_kind_type;

	typedef struct packed {
		logic rdNotWr;
		logic [CHAN_HI_POS-CHAN_LO_POS:0] chanSel;
		pdw_kind_type regKind;
		logic [SET_HI_POS-SET_LO_POS:0] setAddr;
		logic [LVL_HI_POS-LVL_LO_POS:0] levelAddr;
		logic [DATA_HI_POS:0] data;
	} pdw_cmd_type;

endpackage

// ===== pdw_code_corrector.sv
// Gain and offset correction of one channel's input code
`timescale 1ns/1ps
module pdw_code_corrector (
	input wire logic [pdw_pkg::DATA_W-1:0] inputCode,
	input wire logic [pdw_pkg::GAIN_W-1:0] gainCoef,
	input wire logic [pdw_pkg::DATA_W-1:0] offsCoef,
	output logic [pdw_pkg::DATA_W-1:0] correctedCode
);
	import pdw_pkg::*;

	logic [DATA_W-1:0] gainPlusOne;
	logic [2*DATA_W-1:0] product;
	logic signed [DATA_W+2:0] sum;

	// Full-scale gain code plus one means unity, so scale by 2^15
	assign gainPlusOne = {1'b0, gainCoef} + 16'h0001;
	assign product = inputCode * gainPlusOne;
	assign sum = $signed({2'b00, product[2*DATA_W-1:GAIN_W]}) + $signed({3'b000, offsCoef})
		- $signed({3'b000, CODE_MID});

	// Saturate rather than wrap at the code range ends
	always_comb begin
		if (sum < 0) begin
			correctedCode = '0;
		end else if (sum > $signed({3'b000, 16'hFFFF})) begin
			correctedCode = 16'hFFFF;
		end else begin
			correctedCode = sum[DATA_W-1:0];
		end
	end

endmodule // pdw_code_corrector

// ===== pdw_word_decoder.sv
// DAC register command word decoder with per-channel calibration storage
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pdw_word_decoder (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [pdw_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pdw_pkg::BUS_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [pdw_pkg::BUS_W-1:0] regRdData,
	output logic sysWordValid,
	output pdw_pkg::pdw_cmd_type sysWord,
	output logic corrValid,
	output logic [pdw_pkg::CHAN_N-1:0] corrChanMask,
	output logic [pdw_pkg::LEVEL_W-1:0] corrLevelAddr,
	output logic [pdw_pkg::CHAN_N-1:0][pdw_pkg::DATA_W-1:0] corrCode,
	output logic offsetDacValid,
	output logic [pdw_pkg::DATA_W-1:0] offsetDacCode
);
	import pdw_pkg::*;

	// ***********************************************************
	// Declarations
	// ***********************************************************
	logic [GAIN_W-1:0] gainMem [CHAN_N][LEVEL_N];
	logic [DATA_W-1:0] offsMem [CHAN_N][LEVEL_N];
	logic [DATA_W-1:0] inputMem [CHAN_N][LEVEL_N];

	logic [BUS_W-1:0] ctrl_r;
	logic [CMD_W-1:0] cmdLast_r;
	logic [DATA_W-1:0] rdbackData_r;
	logic rdbackValid_r;
	pdw_kind_type lastKind_r;
	logic pendValid_r;
	logic [CHAN_N-1:0] pendMask_r;
	logic [LEVEL_W-1:0] pendAddr_r;
	logic corrValid_r;
	logic [CHAN_N-1:0] corrChanMask_r;
	logic [LEVEL_W-1:0] corrLevelAddr_r;
	logic [CHAN_N-1:0][DATA_W-1:0] corrCode_r;
	logic offsetDacValid_r;
	logic [DATA_W-1:0] offsetDacCode_r;
	logic sysWordValid_r;
	pdw_cmd_type sysWord_r;
	logic [BUS_W-1:0] regRdData_r;

	pdw_cmd_type cmd;
	logic [LEVEL_W-1:0] cmdLevel;
	logic cmdTake;
	logic cmdWrite;
	logic cmdRead;
	logic cmdIsOffsetDac;
	logic [1:0] rbChan;
	logic [DATA_W-1:0] rbValue;
	logic rbClear;
	logic [BUS_W-1:0] rdMux;
	logic [CHAN_N-1:0][DATA_W-1:0] corrected;

	// ***********************************************************
	// Command decode
	// ***********************************************************
	// The word arrives whole in one bus write, so a partial frame never reaches the decode
	assign cmd = pdw_cmd_type'(regWrData[CMD_W-1:0]);
	assign cmdTake = regWr && (regAddr == REG_CMD_OFS) && ctrl_r[CTRL_EN_POS];
	assign cmdWrite = cmdTake && !cmd.rdNotWr;
	assign cmdRead = cmdTake && cmd.rdNotWr;
	assign cmdLevel = {cmd.setAddr, cmd.levelAddr};
	assign cmdIsOffsetDac = (cmdLevel == OFFSET_DAC_ADDR);

	// ***********************************************************
	// Calibration storage
	// ***********************************************************
	// Offset DAC address is skipped here: it has no per-channel registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int ch = 0; ch < CHAN_N; ch++) begin
				for (int a = 0; a < LEVEL_N; a++) begin
					gainMem[ch][a] <= GAIN_RESET;
					offsMem[ch][a] <= OFFS_RESET;
					inputMem[ch][a] <= INPUT_RESET;
				end
			end
		end else if (cmdWrite && !cmdIsOffsetDac) begin
			for (int ch = 0; ch < CHAN_N; ch++) begin
				if (cmd.chanSel[ch]) begin
					case (cmd.regKind)
						KIND_GAIN: begin
							gainMem[ch][cmdLevel] <= cmd.data[DATA_HI_POS:GAIN_LO_POS];
						end
						KIND_OFFS: begin
							offsMem[ch][cmdLevel] <= cmd.data;
						end
						KIND_INPUT: begin
							inputMem[ch][cmdLevel] <= cmd.data;
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// ***********************************************************
	// Shared offset DAC
	// ***********************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offsetDacCode_r <= OFFSET_DAC_RESET;
			offsetDacValid_r <= 1'b0;
		end else begin
			// Gain and offset kinds at this address have no target and are dropped
			offsetDacValid_r <= cmdWrite && cmdIsOffsetDac && (cmd.regKind == KIND_INPUT);
			if (cmdWrite && cmdIsOffsetDac && (cmd.regKind == KIND_INPUT)) begin
				offsetDacCode_r <= cmd.data;
			end
		end
	end

	// ***********************************************************
	// Correction pipeline
	// ***********************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pendValid_r <= 1'b0;
			pendMask_r <= '0;
			pendAddr_r <= '0;
		end else begin
			// Only an input write starts a recompute
			pendValid_r <= cmdWrite && !cmdIsOffsetDac && (cmd.regKind == KIND_INPUT)
				&& (cmd.chanSel != '0);
			pendMask_r <= cmd.chanSel;
			pendAddr_r <= cmdLevel;
		end
	end

	// Coefficients are read one cycle after the input write lands
	generate
		for (genvar g = 0; g < CHAN_N; g++) begin : gen_corr
			pdw_code_corrector u_corr (
				.inputCode(inputMem[g][pendAddr_r]),
				.gainCoef(gainMem[g][pendAddr_r]),
				.offsCoef(offsMem[g][pendAddr_r]),
				.correctedCode(corrected[g])
			);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			corrValid_r <= 1'b0;
			corrChanMask_r <= '0;
			corrLevelAddr_r <= '0;
			corrCode_r <= '0;
		end else begin
			corrValid_r <= pendValid_r;
			if (pendValid_r) begin
				corrChanMask_r <= pendMask_r;
				corrLevelAddr_r <= pendAddr_r;
				for (int ch = 0; ch < CHAN_N; ch++) begin
					if (pendMask_r[ch]) begin
						corrCode_r[ch] <= corrected[ch];
					end
				end
			end
		end
	end

	// ***********************************************************
	// System word hand-off
	// ***********************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sysWordValid_r <= 1'b0;
			sysWord_r <= '0;
		end else begin
			sysWordValid_r <= cmdTake && (cmd.regKind == KIND_SYS);
			if (cmdTake && (cmd.regKind == KIND_SYS)) begin
				sysWord_r <= cmd;
			end
		end
	end

	// ***********************************************************
	// Readback
	// ***********************************************************
	// Several channels selected: the lowest one answers
	always_comb begin
		rbChan = 2'd0;
		for (int ch = CHAN_N - 1; ch >= 0; ch--) begin
			if (cmd.chanSel[ch]) begin
				rbChan = ch[1:0];
			end
		end
	end

	always_comb begin
		case (cmd.regKind)
			KIND_GAIN: begin
				rbValue = {gainMem[rbChan][cmdLevel], 1'b0};
			end
			KIND_OFFS: begin
				rbValue = offsMem[rbChan][cmdLevel];
			end
			KIND_INPUT: begin
				rbValue = cmdIsOffsetDac ? offsetDacCode_r : inputMem[rbChan][cmdLevel];
			end
			default: begin
				rbValue = '0;
			end
		endcase
	end

	assign rbClear = regRd && (regAddr == REG_RDBACK_OFS);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdbackData_r <= '0;
			rdbackValid_r <= 1'b0;
		end else begin
			if (cmdRead && (cmd.regKind != KIND_SYS)) begin
				rdbackData_r <= rbValue;
				rdbackValid_r <= 1'b1;
			end else if (rbClear) begin
				// A new readback in the clearing cycle keeps the flag set
				rdbackValid_r <= 1'b0;
			end
		end
	end

	// ***********************************************************
	// Register bus
	// ***********************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (regWr && (regAddr == REG_CTRL_OFS)) begin
			ctrl_r <= {{(BUS_W-1){1'b0}}, regWrData[CTRL_EN_POS]};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmdLast_r <= '0;
			lastKind_r <= KIND_SYS;
		end else if (cmdTake) begin
			cmdLast_r <= regWrData[CMD_W-1:0];
			lastKind_r <= cmd.regKind;
		end
	end

	always_comb begin
		case (regAddr)
			REG_CMD_OFS: begin
				rdMux = {{(BUS_W-CMD_W){1'b0}}, cmdLast_r};
			end
			REG_RDBACK_OFS: begin
				rdMux = {{(BUS_W-DATA_W){1'b0}}, rdbackData_r};
			end
			REG_STATUS_OFS: begin
				rdMux = '0;
				rdMux[STAT_RBVALID_POS] = rdbackValid_r;
				rdMux[STAT_PEND_POS] = pendValid_r;
				rdMux[STAT_KIND_LO_POS+1:STAT_KIND_LO_POS] = lastKind_r;
			end
			REG_CTRL_OFS: begin
				rdMux = ctrl_r;
			end
			default: begin
				rdMux = '0;
			end
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData_r <= '0;
		end else begin
			regRdData_r <= regRd ? rdMux : '0;
		end
	end

	// ***********************************************************
	// Outputs
	// ***********************************************************
	assign regRdData = regRdData_r;
	assign sysWordValid = sysWordValid_r;
	assign sysWord = sysWord_r;
	assign corrValid = corrValid_r;
	assign corrChanMask = corrChanMask_r;
	assign corrLevelAddr = corrLevelAddr_r;
	assign corrCode = corrCode_r;
	assign offsetDacValid = offsetDacValid_r;
	assign offsetDacCode = offsetDacCode_r;

endmodule // pdw_word_decoder

// ===== pdw_word_decoder_props.sv
// Port assertions for the DAC register word decoder
`timescale 1ns/1ps
module pdw_word_decoder_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [pdw_pkg::ADDR_W-1:0] regAddr,
	input wire logic [pdw_pkg::BUS_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [pdw_pkg::BUS_W-1:0] regRdData,
	input wire logic sysWordValid,
	input wire pdw_pkg::pdw_cmd_type sysWord,
	input wire logic corrValid,
	input wire logic [pdw_pkg::CHAN_N-1:0] corrChanMask,
	input wire logic [pdw_pkg::LEVEL_W-1:0] corrLevelAddr,
	input wire logic [pdw_pkg::CHAN_N-1:0][pdw_pkg::DATA_W-1:0] corrCode,
	input wire logic offsetDacValid,
	input wire logic [pdw_pkg::DATA_W-1:0] offsetDacCode
);
	import pdw_pkg::*;
	logic ctrlEn_r;
	pdw_cmd_type w;
	logic cmdWr, cmdOff, inputWr, offsWr, coefWr, sysWr;
	logic [CHAN_N-1:0] mask;
	logic [LEVEL_W-1:0] lvl;
	logic [DATA_W-1:0] wrData;
	logic [CHAN_N*DATA_W-1:0] keepMask;
	// Mirror of the enable bit, so refused commands raise no expectation
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctrlEn_r <= CTRL_RESET[CTRL_EN_POS];
		else if (regWr && regAddr == REG_CTRL_OFS)
			ctrlEn_r <= regWrData[CTRL_EN_POS];
	end
	assign w = regWrData[CMD_W-1:0];
	assign mask = w.chanSel;
	assign lvl = regWrData[SET_HI_POS:LVL_LO_POS];
	assign wrData = w.data;
	assign cmdWr = regWr && regAddr == REG_CMD_OFS && ctrlEn_r;
	assign cmdOff = regWr && regAddr == REG_CMD_OFS && !ctrlEn_r;
	assign inputWr = cmdWr && !w.rdNotWr && w.regKind == KIND_INPUT && lvl != OFFSET_DAC_ADDR && mask != '0;
	assign offsWr = cmdWr && !w.rdNotWr && w.regKind == KIND_INPUT && lvl == OFFSET_DAC_ADDR;
	assign coefWr = cmdWr && !w.rdNotWr && (w.regKind == KIND_GAIN || w.regKind == KIND_OFFS);
	assign sysWr = cmdWr && w.regKind == KIND_SYS;
	always_comb begin
		for (int i = 0; i < CHAN_N; i++)
			keepMask[i*DATA_W +: DATA_W] = {DATA_W{!(corrValid && corrChanMask[i])}};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence inputWrS;
		inputWr;
	endsequence
	sequence corrUpdS;
		corrValid && corrChanMask == $past(mask, 2) && corrLevelAddr == $past(lvl, 2);
	endsequence
	AST_INPUT_UPDATE: assert property (inputWrS |-> ##2 corrUpdS) else $error("corrected update wrong");
	AST_CORR_CAUSE: assert property (corrValid |-> $past(inputWr, 2))
		else $error("corrected pulse without input write");
	AST_COEF_QUIET: assert property (coefWr |-> ##2 !corrValid) else $error("coef write recomputed");
	AST_SYS_WORD: assert property (sysWr |=> sysWordValid && sysWord == $past(w)) else $error("sys word wrong");
	AST_SYS_CAUSE: assert property (sysWordValid |-> $past(sysWr)) else $error("sys pulse without cause");
	AST_OFFS_DAC: assert property (offsWr |=> offsetDacValid && offsetDacCode == $past(wrData))
		else $error("offset dac wrong");
	AST_OFFS_CAUSE: assert property (offsetDacValid |-> $past(offsWr)) else $error("offset dac stray");
	AST_KEEP_CODES: assert property (((corrCode ^ $past(corrCode)) & keepMask) == '0)
		else $error("unselected code moved");
	AST_REFUSED: assert property (cmdOff |=> !sysWordValid && !offsetDacValid)
		else $error("command taken while disabled");
endmodule // pdw_word_decoder_props

bind pdw_word_decoder pdw_word_decoder_props pdw_word_decoder_props_inst (.clk, .rst_n, .regAddr, .regWrData,
	.regWr, .regRd, .regRdData, .sysWordValid, .sysWord, .corrValid, .corrChanMask, .corrLevelAddr, .corrCode,
	.offsetDacValid, .offsetDacCode);

// ===== pdw_host_model.sv
// Host controller model that issues register bus cycles
`timescale 1ns/1ps
module pdw_host_model (
	input wire logic clk,
	output logic [pdw_pkg::ADDR_W-1:0] regAddr,
	output logic [pdw_pkg::BUS_W-1:0] regWrData,
	output logic regWr,
	output logic regRd,
	input wire logic [pdw_pkg::BUS_W-1:0] regRdData
);
	import pdw_pkg::*;
	initial begin
		regAddr = '0;
		regWrData = '0;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		// Stale data would hide a decoder that samples late
		regWrData <= ~d;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask
	// Callers pass mapped level codes only
	task automatic cmd(input logic r, input logic [3:0] m, input pdw_kind_type k, input logic [5:0] a,
		input logic [15:0] d);
		pdw_cmd_type c;
		c = '{r, m, k, a[5:3], a[2:0], d};
		wr(REG_CMD_OFS, {3'h0, c});
	endtask
endmodule // pdw_host_model

// ===== testbench.sv
// Self-checking testbench of the DAC register word decoder
`timescale 1ns/1ps
module testbench;
	import pdw_pkg::*;
	logic clk, rst_n, regWr, regRd, sysWordValid, corrValid, offsetDacValid;
	logic [ADDR_W-1:0] regAddr;
	logic [BUS_W-1:0] regWrData, regRdData;
	pdw_cmd_type sysWord;
	logic [CHAN_N-1:0] corrChanMask;
	logic [LEVEL_W-1:0] corrLevelAddr;
	logic [CHAN_N-1:0][DATA_W-1:0] corrCode;
	logic [DATA_W-1:0] offsetDacCode;
	int fails = 0;
	int checkCount = 0;
	int cycles = 0;
	pdw_host_model pdw_host_model_inst (.clk, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
	pdw_word_decoder pdw_word_decoder_inst (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.sysWordValid, .sysWord, .corrValid, .corrChanMask, .corrLevelAddr, .corrCode, .offsetDacValid,
		.offsetDacCode);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run needs under a hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			stopTest();
		end
	end
	task automatic cmp(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stopTest();
		$display("Checks %0d, mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmd(input logic r, input logic [3:0] m, input pdw_kind_type k, input logic [5:0] a,
		input logic [15:0] d);
		pdw_host_model_inst.cmd(r, m, k, a, d);
	endtask
	task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] exp);
		logic [BUS_W-1:0] d;
		pdw_host_model_inst.rd(a, d);
		cmp(d, exp);
	endtask
	task automatic testResetRegs();
		rdChk(REG_CTRL_OFS, CTRL_RESET);
		rdChk(REG_STATUS_OFS, '0);
		rdChk(8'h10, '0);
	endtask
	task automatic testSysWord();
		for (int r = 0; r < 2; r++) begin
			cmd(r[0], 4'hA, KIND_SYS, 6'h2A, 16'h5AA5);
			#1;
			cmp(sysWordValid, 1);
			cmp(sysWord, {r[0], 12'hA2A, 16'h5AA5});
		end
	endtask
	task automatic testCoefRead();
		pdw_kind_type k[3] = '{KIND_GAIN, KIND_OFFS, KIND_INPUT};
		logic [15:0] d[3] = '{16'h1235, 16'hABCD, 16'h4321};
		logic [15:0] e[3] = '{16'h1234, 16'hABCD, 16'h4321};
		logic [BUS_W-1:0] s;
		for (int i = 0; i < 3; i++) begin
			cmd(0, 4'h4, k[i], 6'h14, d[i]);
			cmd(1, 4'h4, k[i], 6'h14, 16'h0);
			pdw_host_model_inst.rd(REG_STATUS_OFS, s);
			cmp(s[STAT_RBVALID_POS], 1);
			rdChk(REG_RDBACK_OFS, {16'h0, e[i]});
			pdw_host_model_inst.rd(REG_STATUS_OFS, s);
			cmp(s[STAT_RBVALID_POS], 0);
		end
		// Input 0x4321 through gain 0x091A and offset 0xABCD
		cmp(corrCode[2], 16'h3093);
	endtask
	task automatic testMultiInput();
		cmd(0, 4'h5, KIND_INPUT, 6'h0D, 16'h3C3C);
		@(posedge clk);
		#1;
		cmp(corrValid, 1);
		cmp(corrChanMask, 4'h5);
		cmp(corrLevelAddr, 6'h0D);
		// Channels 1 and 3 have not been recomputed since reset
		for (int i = 0; i < CHAN_N; i++)
			cmp(corrCode[i], (i % 2 == 0) ? 16'h3C3C : 16'h0000);
		@(posedge clk);
		#1;
		cmp(corrValid, 0);
	endtask
	task automatic testDisable();
		pdw_host_model_inst.wr(REG_CTRL_OFS, 32'h0000_0000);
		cmd(0, 4'hF, KIND_SYS, 6'h01, 16'h0001);
		#1;
		cmp(sysWordValid, 0);
		rdChk(REG_CMD_OFS, 32'h11C0_0000);
		rdChk(REG_STATUS_OFS, 32'h0000_000C);
		pdw_host_model_inst.wr(REG_CTRL_OFS, 32'h0000_0001);
		rdChk(REG_CTRL_OFS, 32'h0000_0001);
	endtask
	task automatic testSetLevel();
		logic [5:0] a[3] = '{6'h15, 6'h0D, 6'h14};
		logic [15:0] e[3] = '{16'h1111, 16'h0, 16'h0};
		cmd(0, 4'h2, KIND_INPUT, 6'h15, 16'h1111);
		for (int i = 0; i < 3; i++) begin
			cmd(1, 4'h2, KIND_INPUT, a[i], 16'h0);
			rdChk(REG_RDBACK_OFS, {16'h0, e[i]});
		end
	endtask
	task automatic testOffsetDac();
		cmd(0, 4'hF, KIND_INPUT, OFFSET_DAC_ADDR, 16'h7E57);
		#1;
		cmp(offsetDacValid, 1);
		cmp(offsetDacCode, 16'h7E57);
		cmd(0, 4'hF, KIND_GAIN, OFFSET_DAC_ADDR, 16'h1111);
		#1;
		cmp(offsetDacValid, 0);
		cmd(1, 4'h1, KIND_INPUT, OFFSET_DAC_ADDR, 16'h0);
		rdChk(REG_RDBACK_OFS, 32'h0000_7E57);
	endtask
	initial begin
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		testResetRegs();
		testSysWord();
		testCoefRead();
		testMultiInput();
		testSetLevel();
		testOffsetDac();
		testDisable();
		stopTest();
	end
endmodule // testbench
